// file: logic/sfsq_defines.svh
// constants for the serial flash command sequencer
// assumes a 50 MHz system clock and a host in SPI mode 0
// What this block does
// R1: fast read takes opcode, 24-bit address, eight dummy clocks, then data
// R2: serial input is ignored during the dummy clocks
// R3: dual read drives data on serial output and shared pin
// R4: dual read also takes 24-bit address and eight dummy clocks
// R5: host releases shared pin before first data-out falling edge
// R6: page program carries opcode, 24-bit address, one or more bytes
// R7: one program writes at most 256 bytes into erased cells
// R8: page program needs write enable latch set
// R9: host holds chip select low through the whole program transfer
// R10: program address wraps inside the 256-byte page
// R11: program runs only if chip select rises on a byte boundary
// R12: self-timed program keeps write in progress high until done
// R13: finished program or erase clears write enable latch
// R14: program, sector or block erase into protected area is dropped
// R15: sector erase clears the addressed 4 kB sector to ones
// R16: block erase clears the addressed 64 kB block to ones
// R17: chip erase clears the array; chip select must rise after eighth bit
// R18: chip erase refused when any protection is set
// R19: all erases need write enable latch set
// R20: sector and block erase need chip select rise after last address byte
// R21: self-timed erase keeps write in progress high, status still readable
// R22: write enable opcode sets the write enable latch
// R23: status read is served at any time, even while busy
// R24: dual read sends two bits per clock, odd bit on serial output
// R25: while busy every opcode but status read is ignored
`ifndef SFSQ_DEFINES_SVH
`define SFSQ_DEFINES_SVH
`define SFSQ_OPC_FAST     8'h0B
`define SFSQ_OPC_DUAL     8'h3B
`define SFSQ_OPC_PAGE     8'h02
`define SFSQ_OPC_SECT     8'h20
`define SFSQ_OPC_BLK      8'hD8
`define SFSQ_OPC_CHIP     8'hC7
`define SFSQ_OPC_WREN     8'h06
`define SFSQ_OPC_STAT     8'h05
`define SFSQ_ADDR_BYTES   2'h3
`define SFSQ_BLOCKS       4'h8
`define SFSQ_BP_ALL       4'h4
`define SFSQ_CLK_MHZ      50
`define SFSQ_PAGE_WRITE_TIME_US   1500
`define SFSQ_SECTOR_CLEAR_TIME_MS 50
`define SFSQ_BLOCK_CLEAR_TIME_MS  500
`define SFSQ_ARRAY_CLEAR_TIME_MS  3500
`define SFSQ_PAGE_WRITE_CYC   (`SFSQ_PAGE_WRITE_TIME_US * `SFSQ_CLK_MHZ)
`define SFSQ_SECTOR_CLEAR_CYC (`SFSQ_SECTOR_CLEAR_TIME_MS * 1000 * `SFSQ_CLK_MHZ)
`define SFSQ_BLOCK_CLEAR_CYC  (`SFSQ_BLOCK_CLEAR_TIME_MS * 1000 * `SFSQ_CLK_MHZ)
`define SFSQ_ARRAY_CLEAR_CYC  (`SFSQ_ARRAY_CLEAR_TIME_MS * 1000 * `SFSQ_CLK_MHZ)
`endif

// file: logic/sfsq_pkg.sv
// types shared by the flash command sequencer
// assumes nothing beyond a SystemVerilog tool
package sfsq_pkg;
    typedef enum logic [2:0] {PH_OPC, PH_ADDR, PH_DUMMY, PH_RDATA, PH_PDATA,
                              PH_STAT, PH_END, PH_IGN} sfsq_phase_t;
    typedef enum logic [1:0] {EX_IDLE, EX_PGM, EX_ERS, EX_WAIT} sfsq_exec_t;
    typedef enum logic [1:0] {OP_PROG, OP_SECT, OP_BLK, OP_CHIP} sfsq_arr_op_t;
    typedef struct packed {
        sfsq_arr_op_t op;
        logic [23:0]  addr;
        logic [7:0]   data;
    } sfsq_arr_entry_t;
    typedef struct packed {
        logic [2:0]          cs;
        logic [2:0]          sck;
        logic [1:0]          si;
        sfsq_phase_t         sph;
        logic [2:0]          bitc;
        logic [7:0]          sh;
        logic [7:0]          opc;
        logic [1:0]          nb;
        logic [23:0]         addr;
        logic [7:0]          pidx;
        logic [255:0][7:0]   pbuf;
        logic [255:0]        pmask;
        logic [2:0]          ob;
        logic [7:0]          rsh;
        logic                so;
        logic                so_oe;
        logic                sio;
        logic                sio_oe;
        logic                write_enable_latch;
        sfsq_exec_t          ex;
        sfsq_arr_op_t        aop;
        logic [7:0]          widx;
        logic [31:0]         tmr;
    } sfsq_state_t;
endpackage

// file: logic/sfsq_top.sv
// flash command sequencer: spi command decode, page latch, self-timed cycles
// assumes the array answers o_rd_addr one clock later and accepts entries
// from the array fifo at its own pace; protect bits come from the status logic
`timescale 1ns/100ps
`default_nettype none
`include "sfsq_defines.svh"

module sfsq_fifo #(
    parameter int W     = 34,
    parameter int DEPTH = 4
) (
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_valid,
    input  wire logic [W-1:0] i_data,
    output logic              o_ready,
    output logic              o_valid,
    output logic [W-1:0]      o_data,
    input  wire logic         i_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             wp;
        logic [AW:0]             rp;
    } sfsq_fifo_state_t;
    sfsq_fifo_state_t q, d;
    logic full;
    logic empty;

    assign full    = (q.wp ^ q.rp) == {1'b1, {AW{1'b0}}};
    assign empty   = q.wp == q.rp;
    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data  = q.mem[q.rp[AW-1:0]];

    always_comb begin
        d = q;
        if (i_valid && !full) begin
            d.mem[q.wp[AW-1:0]] = i_data;
            d.wp = q.wp + 1'b1;
        end
        if (i_ready && !empty) begin
            d.rp = q.rp + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

module sfsq_top #(
    parameter int FIFO_DEPTH      = 4,
    parameter int PAGE_WRITE_CYC  = `SFSQ_PAGE_WRITE_CYC,
    parameter int SECTOR_CLR_CYC  = `SFSQ_SECTOR_CLEAR_CYC,
    parameter int BLOCK_CLR_CYC   = `SFSQ_BLOCK_CLEAR_CYC,
    parameter int ARRAY_CLR_CYC   = `SFSQ_ARRAY_CLEAR_CYC
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_sys_rst,
    input  wire logic                     i_cs_n,
    input  wire logic                     i_sck,
    input  wire logic                     i_sio_in,
    output logic                          o_sio_out,
    output logic                          o_sio_oe,
    output logic                          o_so,
    output logic                          o_so_oe,
    input  wire logic [3:0]               i_protect_bits,
    output logic                          o_write_enable_latch,
    output logic                          o_write_in_progress,
    output logic [23:0]                   o_rd_addr,
    input  wire logic [7:0]               i_rd_data,
    output logic                          o_arr_valid,
    output var sfsq_pkg::sfsq_arr_entry_t o_arr_entry,
    input  wire logic                     i_arr_ready
);
    sfsq_pkg::sfsq_state_t     q, d;
    sfsq_pkg::sfsq_arr_entry_t push_entry;
    logic                      push_valid;
    logic                      push_ready;
    logic                      cs_lo;
    logic                      cs_rise;
    logic                      sck_rise;
    logic                      sck_fall;
    logic                      busy;
    logic                      clean;
    logic [7:0]                nsh;
    logic [7:0]                stat_byte;

    // protection grows down from the top of the array in whole blocks
    function automatic logic prot_f(input logic [3:0] bp, input logic [2:0] blk);
        logic [3:0] n;
        n = (bp == 4'h0) ? 4'h0 : (bp >= `SFSQ_BP_ALL) ? `SFSQ_BLOCKS
                                                   : 4'(4'h1 << (bp - 4'h1));
        return {1'b0, blk} >= (`SFSQ_BLOCKS - n);
    endfunction

    // only the second and third synchroniser stages are looked at
    assign cs_lo     = !q.cs[1];
    assign cs_rise   = q.cs[1] && !q.cs[2];
    assign sck_rise  = cs_lo && q.sck[1] && !q.sck[2];
    assign sck_fall  = cs_lo && !q.sck[1] && q.sck[2];
    assign busy      = q.ex != sfsq_pkg::EX_IDLE;
    assign nsh       = {q.sh[6:0], q.si[1]};
    assign stat_byte = {2'h0, i_protect_bits, q.write_enable_latch, busy};
    assign clean     = (q.bitc == 3'h0) && ((q.sph == sfsq_pkg::PH_END) ||
                       (q.sph == sfsq_pkg::PH_PDATA && |q.pmask)); // R11 R17 R20

    always_comb begin
        d = q;
        push_valid = 1'b0;
        push_entry = '0;
        d.cs  = {q.cs[1:0], i_cs_n};
        d.sck = {q.sck[1:0], i_sck};
        d.si  = {q.si[0], i_sio_in};
        if (sck_rise) begin
            d.bitc = q.bitc + 3'h1;
            d.sh   = nsh;
            if (q.bitc == 3'h7) begin
                case (q.sph)
                    sfsq_pkg::PH_OPC: begin
                        d.opc = nsh;
                        d.nb  = 2'h0;
                        if (busy && nsh != `SFSQ_OPC_STAT) begin
                            d.sph = sfsq_pkg::PH_IGN; // R25
                        end else begin
                            case (nsh)
                                `SFSQ_OPC_FAST, `SFSQ_OPC_DUAL,
                                `SFSQ_OPC_SECT, `SFSQ_OPC_BLK: d.sph = sfsq_pkg::PH_ADDR; // R1 R4
                                `SFSQ_OPC_PAGE: begin
                                    d.sph   = sfsq_pkg::PH_ADDR; // R6
                                    d.pmask = '0;
                                end
                                `SFSQ_OPC_STAT: d.sph = sfsq_pkg::PH_STAT; // R23
                                `SFSQ_OPC_WREN, `SFSQ_OPC_CHIP: d.sph = sfsq_pkg::PH_END;
                                default: d.sph = sfsq_pkg::PH_IGN;
                            endcase
                        end
                    end
                    sfsq_pkg::PH_ADDR: begin
                        d.addr = {q.addr[15:0], nsh};
                        d.nb   = q.nb + 2'h1;
                        if (q.nb == `SFSQ_ADDR_BYTES - 2'h1) begin
                            d.pidx = nsh;
                            case (q.opc)
                                `SFSQ_OPC_FAST, `SFSQ_OPC_DUAL: d.sph = sfsq_pkg::PH_DUMMY;
                                `SFSQ_OPC_PAGE: d.sph = sfsq_pkg::PH_PDATA;
                                default: d.sph = sfsq_pkg::PH_END;
                            endcase
                        end
                    end
                    // eight clocks of whatever is on the input, then data out
                    sfsq_pkg::PH_DUMMY: begin
                        d.sph = sfsq_pkg::PH_RDATA; // R2
                        d.ob  = 3'h0;
                    end
                    sfsq_pkg::PH_PDATA: begin
                        d.pbuf[q.pidx]  = nsh; // R7
                        d.pmask[q.pidx] = 1'b1;
                        d.pidx = q.pidx + 8'h1; // R10
                    end
                    default: ;
                endcase
            end
            // bits past the last expected one spoil the command
            if (q.sph == sfsq_pkg::PH_END) begin
                d.sph = sfsq_pkg::PH_IGN; // R17 R20
            end
        end
        if (sck_fall && (q.sph == sfsq_pkg::PH_RDATA || q.sph == sfsq_pkg::PH_STAT)) begin
            logic [7:0] byte_v;
            byte_v = q.rsh;
            if (q.ob == 3'h0) begin
                if (q.sph == sfsq_pkg::PH_STAT) begin
                    byte_v = stat_byte; // R23
                end else begin
                    byte_v = i_rd_data;
                    d.addr = q.addr + 24'h1;
                end
            end
            d.so    = byte_v[7];
            d.so_oe = 1'b1;
            if (q.sph == sfsq_pkg::PH_RDATA && q.opc == `SFSQ_OPC_DUAL) begin
                d.sio    = byte_v[6]; // R3 R24
                d.sio_oe = 1'b1;
                d.rsh    = {byte_v[5:0], 2'h0};
                d.ob     = q.ob + 3'h2;
            end else begin
                d.rsh = {byte_v[6:0], 1'b0};
                d.ob  = q.ob + 3'h1;
            end
        end
        if (cs_rise && clean && !busy) begin
            case (q.opc)
                `SFSQ_OPC_WREN: d.write_enable_latch = 1'b1; // R22
                `SFSQ_OPC_PAGE: begin
                    if (q.write_enable_latch && !prot_f(i_protect_bits, q.addr[18:16])) begin // R8 R14
                        d.ex   = sfsq_pkg::EX_PGM;
                        d.aop  = sfsq_pkg::OP_PROG;
                        d.widx = 8'h0;
                    end
                end
                `SFSQ_OPC_SECT, `SFSQ_OPC_BLK: begin
                    if (q.write_enable_latch && !prot_f(i_protect_bits, q.addr[18:16])) begin // R14 R19
                        d.ex  = sfsq_pkg::EX_ERS;
                        d.aop = (q.opc == `SFSQ_OPC_SECT) ? sfsq_pkg::OP_SECT
                                                         : sfsq_pkg::OP_BLK; // R15 R16
                    end
                end
                `SFSQ_OPC_CHIP: begin
                    if (q.write_enable_latch && i_protect_bits == 4'h0) begin // R18 R19
                        d.ex  = sfsq_pkg::EX_ERS;
                        d.aop = sfsq_pkg::OP_CHIP; // R17
                    end
                end
                default: ;
            endcase
        end
        if (!cs_lo) begin
            d.sph    = sfsq_pkg::PH_OPC;
            d.bitc   = 3'h0;
            d.ob     = 3'h0;
            d.so_oe  = 1'b0;
            d.sio_oe = 1'b0;
        end
        case (q.ex)
            sfsq_pkg::EX_PGM: begin
                // empty latch slots are skipped so untouched bytes stay as they are
                push_valid = q.pmask[q.widx];
                push_entry = '{op: sfsq_pkg::OP_PROG, addr: {q.addr[23:8], q.widx},
                               data: q.pbuf[q.widx]}; // R10
                if (!push_valid || push_ready) begin
                    d.widx = q.widx + 8'h1;
                    if (q.widx == 8'hFF) begin
                        d.ex  = sfsq_pkg::EX_WAIT;
                        d.tmr = 32'(PAGE_WRITE_CYC); // R12
                    end
                end
            end
            sfsq_pkg::EX_ERS: begin
                push_valid = 1'b1;
                push_entry = '{op: q.aop, addr: q.addr, data: 8'hFF};
                if (push_ready) begin
                    d.ex = sfsq_pkg::EX_WAIT;
                    case (q.aop)
                        sfsq_pkg::OP_SECT: d.tmr = 32'(SECTOR_CLR_CYC); // R21
                        sfsq_pkg::OP_BLK:  d.tmr = 32'(BLOCK_CLR_CYC);
                        default:           d.tmr = 32'(ARRAY_CLR_CYC);
                    endcase
                end
            end
            sfsq_pkg::EX_WAIT: begin
                d.tmr = q.tmr - 32'h1;
                if (q.tmr <= 32'h1) begin
                    d.ex  = sfsq_pkg::EX_IDLE;
                    d.write_enable_latch = 1'b0; // R13
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            q     <= '0;
            q.cs  <= 3'h7;
            q.sph <= sfsq_pkg::PH_OPC;
            q.ex  <= sfsq_pkg::EX_IDLE;
        end else begin
            q <= d;
        end
    end

    // the fifo lets the array run slower than the page walk; a full fifo stalls it
    sfsq_fifo #(
        .W     ($bits(sfsq_pkg::sfsq_arr_entry_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_arr_fifo (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_valid   (push_valid),
        .i_data    (push_entry),
        .o_ready   (push_ready),
        .o_valid   (o_arr_valid),
        .o_data    (o_arr_entry),
        .i_ready   (i_arr_ready)
    );

    assign o_so                 = q.so;
    assign o_so_oe              = q.so_oe;
    assign o_sio_out            = q.sio;
    assign o_sio_oe             = q.sio_oe;
    assign o_write_enable_latch = q.write_enable_latch;
    assign o_write_in_progress  = busy;
    assign o_rd_addr            = q.addr;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_cycle_end;
        o_write_in_progress ##1 !o_write_in_progress;
    endsequence
    sequence s_cycle_start;
        !o_write_in_progress ##1 o_write_in_progress;
    endsequence

    wel_after_done_a: assert property (s_cycle_end |-> !o_write_enable_latch) // R13
        else $error("latch still set after cycle end");
    start_needs_wel_a: assert property (s_cycle_start |-> $past(o_write_enable_latch)) // R8
        else $error("cycle started without latch");
    chip_unprot_a: assert property (s_cycle_start ##0 (q.aop == sfsq_pkg::OP_CHIP)
                       |-> $past(i_protect_bits) == 4'h0) // R18
        else $error("chip erase with protection set");
    dummy_quiet_a: assert property (q.sph == sfsq_pkg::PH_DUMMY |=> $stable(q.addr)) // R2
        else $error("address moved during dummy clocks");
    dual_drive_a: assert property (o_sio_oe |-> q.opc == `SFSQ_OPC_DUAL
                       && q.sph == sfsq_pkg::PH_RDATA) // R3
        else $error("shared pin driven outside dual read");
    page_wrap_a: assert property (o_arr_valid && o_arr_entry.op == sfsq_pkg::OP_PROG
                       |-> o_arr_entry.addr[23:8] == q.addr[23:8]) // R10
        else $error("program left its page");
    busy_ignore_a: assert property (busy && sck_rise && q.sph == sfsq_pkg::PH_OPC
                       && q.bitc == 3'h7 && nsh != `SFSQ_OPC_STAT
                       |=> q.sph == sfsq_pkg::PH_IGN) // R25
        else $error("opcode taken while busy");
    wait_holds_a: assert property (q.ex == sfsq_pkg::EX_WAIT && q.tmr > 32'h2
                       |=> o_write_in_progress [*2]) // R12
        else $error("busy dropped early");
    wren_sets_a: assert property (cs_rise && clean && !busy && q.opc == `SFSQ_OPC_WREN
                       |=> o_write_enable_latch) // R22
        else $error("write enable not latched");
endmodule

`default_nettype wire

// file: testbench/sfsq_host.sv
// spi host model: select, mode 0 serial clock and the shared pin
// assumes i_clk is the design's system clock; one serial clock takes 8 of its cycles
`timescale 1ns/100ps
`default_nettype none
module sfsq_host (
    input  wire logic i_clk,
    input  wire logic i_so,
    input  wire logic i_sio,
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_sio,
    output logic      o_sio_oe
);
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_sio = 1'b0;
        o_sio_oe = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic sel();
        tick(1);
        o_cs_n <= 1'b0;
        o_sio_oe <= 1'b1;
        tick(4);
    endtask
    // sample late in the high phase, well after the device's fall update
    task automatic xbits(input logic [7:0] b, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            o_sck <= 1'b0;
            o_sio <= b[i];
            tick(4);
            o_sck <= 1'b1;
            tick(3);
            @(negedge i_clk) r[i] = i_so;
            tick(1);
        end
    endtask
    // pin let go before the first data fall of a dual read
    task automatic rel();
        o_sio_oe <= 1'b0;
        tick(1);
    endtask
    task automatic xdual(output logic [7:0] r);
        for (int i = 7; i > 0; i -= 2) begin
            o_sck <= 1'b0;
            tick(4);
            o_sck <= 1'b1;
            tick(3);
            @(negedge i_clk) r[i] = i_so;
            r[i-1] = i_sio;
            tick(1);
        end
    endtask
    task automatic desel();
        o_sck <= 1'b0;
        tick(4);
        o_cs_n <= 1'b1;
        o_sio_oe <= 1'b0;
        tick(6);
        @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// file: testbench/tb.sv
// bench: host model on the spi side, array model draining the work fifo
// assumes shortened timed cycles, long enough to poll status while busy
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int PW = 800;
    localparam int SC = 900;
    localparam int BC = 1000;
    localparam int AC = 1100;
    logic       clk = 0;
    logic       rst = 1;
    logic       rdy = 0;
    logic       stall = 0;
    logic       flt = 0;
    logic [3:0] bp = 4'h0;
    logic [7:0] rdd = 8'h00;
    logic       wel_m = 0;
    int         fails = 0;
    int         total_checks = 0;
    int         cyc = 0;
    int         seed;
    wire logic  cs_n, sck, h_d, h_oe, sio_w;
    logic       so, so_oe, sio_o, sio_oe, write_enable_latch, write_in_progress, av;
    logic [23:0] ra;
    sfsq_pkg::sfsq_arr_entry_t ae;
    sfsq_pkg::sfsq_arr_entry_t got_q[$];
    sfsq_pkg::sfsq_arr_entry_t exp_q[$];
    logic [7:0] arr_m[int];
    logic [7:0] ref_m[int];
    always #10 clk = ~clk;
    // undriven pin shows a toggling level, never the last value
    assign sio_w = sio_oe ? sio_o : (h_oe ? h_d : flt);
    sfsq_host host (.i_clk(clk), .i_so(so), .i_sio(sio_w), .o_cs_n(cs_n), .o_sck(sck),
                    .o_sio(h_d), .o_sio_oe(h_oe));
    sfsq_top #(.FIFO_DEPTH(4), .PAGE_WRITE_CYC(PW), .SECTOR_CLR_CYC(SC),
               .BLOCK_CLR_CYC(BC), .ARRAY_CLR_CYC(AC)) dut (
        .i_clk(clk), .i_sys_rst(rst), .i_cs_n(cs_n), .i_sck(sck), .i_sio_in(sio_w),
        .o_sio_out(sio_o), .o_sio_oe(sio_oe), .o_so(so), .o_so_oe(so_oe),
        .i_protect_bits(bp), .o_write_enable_latch(write_enable_latch), .o_write_in_progress(write_in_progress),
        .o_rd_addr(ra), .i_rd_data(rdd), .o_arr_valid(av), .o_arr_entry(ae),
        .i_arr_ready(rdy));
    function automatic int mk(input logic [1:0] op);
        return op == 2'h1 ? 'hFFF000 : op == 2'h2 ? 'hFF0000 : op == 2'h3 ? 0 : 'hFFFFFF;
    endfunction
    function automatic void upd(ref logic [7:0] m[int], input logic [1:0] op, input int a,
                                input logic [7:0] d);
        if (op == 2'h0) m[a] = (m.exists(a) ? m[a] : 8'hFF) & d;
        else foreach (m[k]) if ((k & mk(op)) == (a & mk(op))) m[k] = 8'hFF;
    endfunction
    function automatic logic [7:0] rdm(input int a);
        return ref_m.exists(a) ? ref_m[a] : 8'hFF;
    endfunction
    function automatic bit prot(input int a);
        if (bp == 4'h0) return 1'b0;
        if (bp >= 4'h4) return 1'b1;
        return a[18:16] >= 8 - (1 << (bp - 1));
    endfunction
    // array model: answers one clock after the address, stalls at random
    always @(posedge clk) begin
        cyc <= cyc + 1;
        flt <= ~flt;
        rdd <= arr_m.exists(ra) ? arr_m[ra] : 8'hFF;
        rdy <= !stall && ($urandom % 4 != 0);
        if (av && rdy) begin
            got_q.push_back(ae);
            upd(arr_m, ae.op, ae.addr, ae.data);
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %0h want %0h", $time, m, got, exp);
        end
    endtask
    task automatic cmpq();
        chk(got_q.size(), exp_q.size(), "entry count");
        for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
            chk({got_q[i].op, got_q[i].data, got_q[i].addr & 24'(mk(got_q[i].op))},
                {exp_q[i].op, exp_q[i].data, exp_q[i].addr & 24'(mk(exp_q[i].op))},
                "entry");
        end
        got_q.delete();
        exp_q.delete();
    endtask
    task automatic st(output logic [7:0] r);
        host.sel();
        host.xbits(8'h05, 8, r);
        host.xbits(8'($urandom), 8, r);
        host.desel();
    endtask
    task automatic wren();
        logic [7:0] r;
        host.sel();
        host.xbits(8'h06, 8, r);
        host.desel();
        wel_m = 1'b1;
        chk(write_enable_latch, 1'b1, "latch set");
        st(r);
        chk(r, {2'b00, bp, 2'b10}, "status");
    endtask
    task automatic rd(input logic [7:0] op, input int a, input int n);
        logic [7:0] r;
        host.sel();
        host.xbits(op, 8, r);
        for (int i = 2; i >= 0; i--) host.xbits(8'(a >> (8 * i)), 8, r);
        host.xbits(8'($urandom), 8, r);
        if (op == 8'h3B) host.rel();
        for (int i = 0; i < n; i++) begin
            if (op == 8'h3B) host.xdual(r);
            else host.xbits(8'($urandom), 8, r);
            chk(r, rdm(a + i), "read data");
            chk({so_oe, sio_oe}, {1'b1, op == 8'h3B}, "pin drive");
        end
        host.desel();
        $display("read %h done at %0t", op, $time);
    endtask
    task automatic cmd(input logic [7:0] op, input int a, input int n, input int xb);
        logic [7:0] r;
        logic [7:0] d;
        logic [7:0] pb[256];
        bit         ps[256];
        logic [1:0] ao;
        bit         acc;
        int         off;
        int         c0;
        int         dur;
        ao = (op == 8'h20) ? 2'h1 : (op == 8'hD8) ? 2'h2 : (op == 8'hC7) ? 2'h3 : 2'h0;
        dur = (ao == 2'h0) ? PW : (ao == 2'h1) ? SC : (ao == 2'h2) ? BC : AC;
        acc = wel_m && xb == 0 && (ao == 2'h3 ? bp == 4'h0 : !prot(a)) && (ao != 2'h0 || n > 0);
        off = a & 'hFF;
        // stalled array lets the fifo fill and refuse
        if (n > 8) stall <= 1'b1;
        host.sel();
        host.xbits(op, 8, r);
        for (int i = 2; i >= 0 && ao != 2'h3; i--) host.xbits(8'(a >> (8 * i)), 8, r);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            host.xbits(d, 8, r);
            pb[off] = d;
            ps[off] = 1'b1;
            off = (off + 1) % 256;
        end
        if (xb > 0) host.xbits(8'hA5, xb, r);
        host.desel();
        c0 = cyc;
        chk(write_in_progress, acc, "accept");
        if (acc) begin
            for (int j = 0; j < 256 && ao == 2'h0; j++) if (ps[j]) begin
                exp_q.push_back('{sfsq_pkg::OP_PROG, 24'((a & 'hFFFF00) | j), pb[j]});
                upd(ref_m, 2'h0, (a & 'hFFFF00) | j, pb[j]);
            end
            if (ao != 2'h0) begin
                exp_q.push_back('{sfsq_pkg::sfsq_arr_op_t'(ao), 24'(a), 8'hFF});
                upd(ref_m, ao, a, 8'hFF);
            end
            st(r);
            chk(r, {2'b00, bp, 2'b11}, "busy status");
            stall <= 1'b0;
            host.sel();
            for (int i = 0; i < 4; i++) host.xbits(i == 0 ? 8'h20 : 8'h00, 8, r);
            host.desel();
            for (int i = 0; i < 8000 && write_in_progress !== 1'b0; i++) @(negedge clk);
            if (write_in_progress !== 1'b0) begin
                fails++;
                finish_test();
            end
            chk(write_enable_latch, 1'b0, "latch clear");
            chk(cyc - c0 + 12 >= dur, 1'b1, "busy time");
            wel_m = 1'b0;
        end else begin
            repeat (20) @(negedge clk);
        end
        stall <= 1'b0;
        cmpq();
        $display("command %h done at %0t", op, $time);
    endtask
    initial begin
        #2000000;
        fails++;
        finish_test();
    end
    initial begin
        seed = $urandom(62446);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({so_oe, sio_oe, write_enable_latch, write_in_progress, av}, 5'h00, "reset");
        cmd(8'h02, 'h010010, 4, 0);
        wren();
        cmd(8'h02, 'h0100F0, 20, 0);
        wren();
        cmd(8'h02, 'h010040, 3, 4);
        cmd(8'h02, 'h030080, 260, 0);
        rd(8'h0B, 'h0100EE, 6);
        rd(8'h3B, 'h03007C, 8);
        for (int k = 1; k < 6; k++) begin
            bp <= 4'(k);
            wren();
            cmd(8'h20, 'h070000, 0, 0);
        end
        cmd(8'hC7, 0, 0, 0);
        bp <= 4'h1;
        cmd(8'h20, 'h030000, 0, 4);
        cmd(8'hD8, 'h030000, 0, 8);
        cmd(8'h20, 'h030123, 0, 0);
        rd(8'h0B, 'h03007E, 4);
        bp <= 4'h0;
        wren();
        cmd(8'hC7, 0, 0, 8);
        cmd(8'hC7, 0, 0, 0);
        rd(8'h0B, 'h0100FE, 4);
        wren();
        cmd(8'h02, 'h01ABCD, 5, 0);
        wren();
        cmd(8'hD8, 'h01F00F, 0, 0);
        rd(8'h3B, 'h01ABCC, 6);
        finish_test();
    end
endmodule
`default_nettype wire
